//--- dacctl_top.sv
// Purpose: control, data latch, update flag and vector for a 12-bit DAC
// Assumes: single 50 MHz clock, triggers synchronous to it
// Notes:   register port answers reads one cycle after the strobe
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps

module dacctl_top
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  // register port
  input  wire dacctl_pkg::dacctl_req_t req,
  output logic [15:0]                 rdata,
  // load triggers
  input  wire logic [1:0]             trigger,
  // dma handshake
  input  wire logic                   dma_ack,
  output logic                        dma_req,
  // interrupt
  output logic                        irq,
  // analog side
  output dacctl_pkg::dacctl_analog_t  analog
);
  import dacctl_pkg::*;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic                     cell_en_q;
  logic                     dac_on_q;
  logic                     irq_en_q;
  logic                     dma_en_q;
  logic                     ref_q;
  logic [1:0]               lsel_q;
  logic                     gate_q;
  logic [DACCTL_CODE_W-1:0] code_q;
  logic [DACCTL_CODE_W-1:0] latch_q;
  logic                     flag_q;
  logic                     flag_d;
  logic [1:0]               trig_q;
  logic                     dma_req_q;
  logic                     load;
  logic                     code_wr;
  logic [1:0]               trig_rise;
  logic                     vec_rd;
  logic                     cfg_open;
  logic [DACCTL_CODE_W-1:0] wcode;

  assign code_wr  = req.wr && req.addr == DACCTL_ADDR_CODE;
  assign vec_rd   = req.rd && req.addr == DACCTL_ADDR_VECTOR;
  assign cfg_open = !dac_on_q;
  assign wcode    = req.wdata[DACCTL_CODE_W-1:0];

  // ------------------------------------------------------------------
  // control writes
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cell_en_q <= 1'b0;
      dac_on_q  <= 1'b0;
      irq_en_q  <= 1'b0;
      dma_en_q  <= 1'b0;
      ref_q     <= 1'b0;
      lsel_q    <= 2'h0;
    end else if (req.wr) begin
      if (req.addr == DACCTL_ADDR_CELL) begin
        cell_en_q <= req.wdata[DACCTL_BIT_CELL_EN];
      end
      if (req.addr == DACCTL_ADDR_CTRL) begin
        // the on bit itself stays writable so software can switch off
        dac_on_q <= req.wdata[DACCTL_BIT_ON];
        if (cfg_open) begin
          irq_en_q <= req.wdata[DACCTL_BIT_IRQ_EN];
          dma_en_q <= req.wdata[DACCTL_BIT_DMA_EN];
          ref_q    <= req.wdata[DACCTL_BIT_REF];
          lsel_q   <= req.wdata[DACCTL_LSEL_HI:DACCTL_LSEL_LO];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // code word and gate
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      code_q <= '0;
    end else if (code_wr) begin
      code_q <= req.wdata[DACCTL_CODE_W-1:0];
    end
  end

  // gate enable lives in status bit 1; guarded like the rest of status
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gate_q <= 1'b0;
    end else if (req.wr && req.addr == DACCTL_ADDR_STAT && cfg_open) begin
      gate_q <= req.wdata[DACCTL_BIT_GATE];
    end
  end

  // ------------------------------------------------------------------
  // trigger edges and latch load
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trig_q <= 2'h0;
    end else begin
      trig_q <= trigger;
    end
  end

  assign trig_rise = trigger & ~trig_q;

  always_comb begin
    load = 1'b0;
    case (dacctl_lsel_t'(lsel_q))
      DACCTL_LOAD_ON_WRITE: load = code_wr;
      DACCTL_LOAD_TRIG0:    load = trig_rise[0] && gate_q;
      DACCTL_LOAD_TRIG1:    load = trig_rise[1] && gate_q;
      default:              load = 1'b0;
    endcase
  end

  // on-write uses the new word directly so latch follows the write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= '0;
    end else if (load) begin
      latch_q <= code_wr ? req.wdata[DACCTL_CODE_W-1:0] : code_q;
    end
  end

  // ------------------------------------------------------------------
  // update flag: set wins over every clear
  // ------------------------------------------------------------------
  always_comb begin
    flag_d = flag_q;
    if (req.wr && req.addr == DACCTL_ADDR_STAT && cfg_open &&
        req.wdata[DACCTL_BIT_FLAG]) begin
      flag_d = 1'b0;
    end
    if (vec_rd) begin
      flag_d = 1'b0;
    end
    if (dma_en_q && dma_ack) begin
      flag_d = 1'b0;
    end
    if (load) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ------------------------------------------------------------------
  // dma request: held until accepted or dma is disabled, new update re-raises it
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dma_req_q <= 1'b0;
    end else if (load && dma_en_q) begin
      dma_req_q <= 1'b1;
    end else if (dma_ack || !dma_en_q) begin
      dma_req_q <= 1'b0;
    end
  end

  assign dma_req = dma_req_q;
  assign irq     = flag_q && irq_en_q;

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= DACCTL_RESET_VAL;
    end else if (req.rd) begin
      rdata <= DACCTL_RESET_VAL;
      case (req.addr)
        DACCTL_ADDR_CELL: rdata[DACCTL_BIT_CELL_EN] <= cell_en_q;
        DACCTL_ADDR_CTRL: begin
          rdata[DACCTL_BIT_ON]     <= dac_on_q;
          rdata[DACCTL_BIT_IRQ_EN] <= irq_en_q;
          rdata[DACCTL_BIT_DMA_EN] <= dma_en_q;
          rdata[DACCTL_LSEL_HI:DACCTL_LSEL_LO] <= lsel_q;
          rdata[DACCTL_BIT_REF]    <= ref_q;
        end
        DACCTL_ADDR_CODE: rdata[DACCTL_CODE_W-1:0] <= code_q;
        DACCTL_ADDR_STAT: begin
          rdata[DACCTL_BIT_FLAG] <= flag_q;
          rdata[DACCTL_BIT_GATE] <= gate_q;
        end
        DACCTL_ADDR_VECTOR: begin
          rdata <= flag_q ? DACCTL_VEC_UPD : DACCTL_VEC_NONE;
        end
        default: rdata <= DACCTL_RESET_VAL;
      endcase
    end else begin
      rdata <= DACCTL_RESET_VAL;
    end
  end

  // ------------------------------------------------------------------
  // analog side
  // ------------------------------------------------------------------
  assign analog = '{dac_on:             dac_on_q,
                    reference_choice:   ref_q,
                    analog_cell_enable: cell_en_q,
                    latch:              latch_q};

  // ------------------------------------------------------------------
  // checks: register access
  // ------------------------------------------------------------------
  chk_ctrl_locked: assert property (
    @(posedge clock) disable iff (!rst_b)
    $past(dac_on_q) && $past(req.wr) && dac_on_q
    |-> $stable(ref_q) && $stable(lsel_q) && $stable(irq_en_q)
    && $stable(dma_en_q)) else $error("control changed while on");

  chk_stat_locked: assert property (
    @(posedge clock) disable iff (!rst_b)
    dac_on_q && req.wr && req.addr == DACCTL_ADDR_STAT
    |=> $stable(gate_q)) else $error("gate changed while on");

  chk_code_read: assert property (
    @(posedge clock) disable iff (!rst_b)
    $past(req.rd) && $past(req.addr) == DACCTL_ADDR_CODE
    |-> rdata[DACCTL_CODE_W-1:0] == $past(code_q))
    else $error("code word read wrong");

  chk_code_upper: assert property (
    @(posedge clock) disable iff (!rst_b)
    $past(req.rd) && $past(req.addr) == DACCTL_ADDR_CODE
    |-> rdata[15:DACCTL_CODE_W] == 4'h0)
    else $error("code upper bits nonzero");

  chk_vec_clear: assert property (
    @(posedge clock) disable iff (!rst_b)
    vec_rd && flag_q && !load
    |=> !flag_q && rdata == DACCTL_VEC_UPD)
    else $error("vector read wrong");

  chk_vec_idle: assert property (
    @(posedge clock) disable iff (!rst_b)
    vec_rd && !flag_q |=> rdata == DACCTL_VEC_NONE)
    else $error("idle vector not zero");

  // ------------------------------------------------------------------
  // checks: loads, flag and requests
  // ------------------------------------------------------------------
  chk_write_load: assert property (
    @(posedge clock) disable iff (!rst_b)
    code_wr && lsel_q == DACCTL_LOAD_ON_WRITE
    |=> latch_q == $past(wcode)) else $error("on-write load missed");

  chk_resv_noload: assert property (
    @(posedge clock) disable iff (!rst_b)
    lsel_q == DACCTL_LOAD_RESERVED |=> $stable(latch_q))
    else $error("reserved select loaded");

  chk_trig_load: assert property (
    @(posedge clock) disable iff (!rst_b)
    lsel_q == DACCTL_LOAD_TRIG0 && trigger[0] && !trig_q[0] && gate_q
    && !code_wr |=> latch_q == $past(code_q))
    else $error("trigger load missed");

  chk_trig1_load: assert property (
    @(posedge clock) disable iff (!rst_b)
    lsel_q == DACCTL_LOAD_TRIG1 && trigger[1] && !trig_q[1] && gate_q
    && !code_wr |=> latch_q == $past(code_q))
    else $error("second trigger load missed");

  chk_gate_block: assert property (
    @(posedge clock) disable iff (!rst_b)
    lsel_q[1] && !gate_q |=> $stable(latch_q))
    else $error("latch moved with gate closed");

  chk_dma_raise: assert property (
    @(posedge clock) disable iff (!rst_b)
    load && dma_en_q |=> dma_req) else $error("dma request missing");

  chk_dma_hold: assert property (
    @(posedge clock) disable iff (!rst_b)
    dma_req && dma_en_q && !dma_ack |=> dma_req)
    else $error("dma request dropped early");

  chk_dma_idle: assert property (
    @(posedge clock) disable iff (!rst_b)
    !dma_en_q |=> !dma_req) else $error("dma request while disabled");

  chk_flag_set: assert property (
    @(posedge clock) disable iff (!rst_b)
    load |=> flag_q) else $error("update flag not set");

  chk_w1c_clear: assert property (
    @(posedge clock) disable iff (!rst_b)
    req.wr && req.addr == DACCTL_ADDR_STAT && cfg_open
    && req.wdata[DACCTL_BIT_FLAG] && !load |=> !flag_q)
    else $error("write one did not clear");

  chk_w0_keep: assert property (
    @(posedge clock) disable iff (!rst_b)
    req.wr && req.addr == DACCTL_ADDR_STAT && !req.wdata[DACCTL_BIT_FLAG]
    && flag_q && !(dma_en_q && dma_ack) |=> flag_q)
    else $error("write zero cleared flag");

  chk_dma_clear: assert property (
    @(posedge clock) disable iff (!rst_b)
    dma_en_q && dma_ack && !load |=> !flag_q)
    else $error("dma accept did not clear");

  chk_irq_line: assert property (
    @(posedge clock) disable iff (!rst_b)
    $past(load) && irq_en_q |-> irq)
    else $error("irq missing after update");

  chk_irq_drop: assert property (
    @(posedge clock) disable iff (!rst_b)
    $past(vec_rd) && !$past(load) |-> !irq)
    else $error("irq held after clear");

endmodule

//--- dacctl_pkg.sv
// Purpose: constants and types for the converter control and status logic
// Assumes: 16-bit register port, word offsets as byte addresses
// Notes:   shared by the design module and the testbench
package dacctl_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] DACCTL_ADDR_CELL   = 4'h0;
  localparam logic [3:0] DACCTL_ADDR_CTRL   = 4'h4;
  localparam logic [3:0] DACCTL_ADDR_CODE   = 4'h6;
  localparam logic [3:0] DACCTL_ADDR_STAT   = 4'h8;
  localparam logic [3:0] DACCTL_ADDR_VECTOR = 4'ha;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int DACCTL_BIT_ON      = 0;
  localparam int DACCTL_BIT_IRQ_EN  = 1;
  localparam int DACCTL_BIT_DMA_EN  = 2;
  localparam int DACCTL_LSEL_LO     = 8;
  localparam int DACCTL_LSEL_HI     = 9;
  localparam int DACCTL_BIT_REF     = 12;
  localparam int DACCTL_BIT_FLAG    = 0;
  localparam int DACCTL_BIT_GATE    = 1;
  localparam int DACCTL_BIT_CELL_EN = 10;
  localparam int DACCTL_CODE_W      = 12;

  // ------------------------------------------------------------------
  // values
  // ------------------------------------------------------------------
  localparam logic [15:0] DACCTL_RESET_VAL = 16'h0000;
  localparam logic [15:0] DACCTL_VEC_NONE  = 16'h0000;
  localparam logic [15:0] DACCTL_VEC_UPD   = 16'h0004;

  typedef enum logic [1:0] {
    DACCTL_LOAD_ON_WRITE = 2'h0,
    DACCTL_LOAD_RESERVED = 2'h1,
    DACCTL_LOAD_TRIG0    = 2'h2,
    DACCTL_LOAD_TRIG1    = 2'h3
  } dacctl_lsel_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dacctl_req_t;

  typedef struct packed {
    logic                        dac_on;
    logic                        reference_choice;
    logic                        analog_cell_enable;
    logic [DACCTL_CODE_W-1:0]    latch;
  } dacctl_analog_t;

endpackage

//--- dacctl_dma_model.sv
// Purpose: DMA controller stand-in that accepts converter requests
// Assumes: the request stays high until it is accepted
// Notes:   ack_wait sets how long it stalls before accepting
`timescale 1ns/10ps
module dacctl_dma_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // handshake
  input  wire logic       dma_req,
  input  wire logic [3:0] ack_wait,
  output logic            dma_ack
);
  logic [3:0] wait_q;
  logic       done_q;

  // one acceptance per request: the request is still high in the cycle
  // after the ack, so wait for its drop before counting again
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wait_q  <= 4'h0;
      done_q  <= 1'b0;
      dma_ack <= 1'b0;
    end else if (!dma_req) begin
      wait_q  <= 4'h0;
      done_q  <= 1'b0;
      dma_ack <= 1'b0;
    end else if (dma_ack || done_q) begin
      dma_ack <= 1'b0;
      done_q  <= 1'b1;
    end else if (wait_q == ack_wait) begin
      dma_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

//--- testbench.sv
// Purpose: self-checking bench for the converter control logic
// Assumes: register port strobes one cycle, read data one cycle later
// Notes:   triggers are driven here, DMA acceptance by the model
`timescale 1ns/10ps
module testbench;
  import dacctl_pkg::*;
  logic           clock;
  logic           rst_b;
  dacctl_req_t    req;
  logic [15:0]    rdata;
  logic [1:0]     trigger;
  logic           dma_ack;
  logic           dma_req;
  logic           irq;
  dacctl_analog_t analog;
  logic [3:0]     ack_wait;
  logic [15:0]    rd_v;
  int             mismatches;
  int             tests_run;
  int             n;

  dacctl_top DUT (.clock(clock), .rst_b(rst_b), .req(req), .rdata(rdata),
    .trigger(trigger), .dma_ack(dma_ack), .dma_req(dma_req), .irq(irq),
    .analog(analog));
  dacctl_dma_model dma (.clock(clock), .rst_b(rst_b), .dma_req(dma_req),
    .ack_wait(ack_wait), .dma_ack(dma_ack));

  always #10 clock = ~clock;

  // ------------------------------------------------------------------
  // access tasks: whole 16-bit words only
  // ------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1 rd_v = rdata;
  endtask

  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    rd(a);
    chk("read", e, rd_v);
  endtask

  task automatic pulse(input int k);
    @(posedge clock);
    trigger[k] <= 1'b1;
    repeat (2) @(posedge clock);
    trigger[k] <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // bounded wait so a dead request line cannot hang the run
  task automatic wait_dma(input logic lvl);
    for (int k = 0; k < 20 && dma_req !== lvl; k++) begin
      @(posedge clock);
      #1;
    end
    chk("dma_req", {15'h0, lvl}, {15'h0, dma_req});
  endtask

  task automatic end_sim;
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #100us;
    mismatches++;
    $display("mismatch watchdog expected done seen timeout");
    end_sim();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    clock = 0;
    rst_b = 0;
    req = '0;
    trigger = 2'h0;
    ack_wait = 4'h0;
    mismatches = 0;
    tests_run = 0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    for (n = 0; n < 12; n += 2) rchk(4'(n), 16'h0000);
    wr(DACCTL_ADDR_CODE, 16'hfabc);
    rchk(DACCTL_ADDR_CODE, 16'h0abc);
    chk("latch", 16'h0abc, {4'h0, analog.latch});
    rchk(DACCTL_ADDR_STAT, 16'h0001);
    wr(DACCTL_ADDR_STAT, 16'h0000);
    rchk(DACCTL_ADDR_STAT, 16'h0001);
    wr(DACCTL_ADDR_STAT, 16'h0001);
    rchk(DACCTL_ADDR_STAT, 16'h0000);
    wr(DACCTL_ADDR_CTRL, 16'h0002);
    wr(DACCTL_ADDR_CODE, 16'h0123);
    chk("irq", 16'h1, {15'h0, irq});
    rchk(DACCTL_ADDR_VECTOR, 16'h0004);
    chk("irq", 16'h0, {15'h0, irq});
    rchk(DACCTL_ADDR_VECTOR, 16'h0000);
    wr(DACCTL_ADDR_CTRL, 16'h0000);
    wr(DACCTL_ADDR_CODE, 16'h0123);
    chk("irq", 16'h0, {15'h0, irq});
    rd(DACCTL_ADDR_VECTOR);
    // trigger loads: gate closed, wrong line, right line
    wr(DACCTL_ADDR_CTRL, 16'h0200);
    wr(DACCTL_ADDR_CODE, 16'h0555);
    pulse(0);
    chk("latch", 16'h0123, {4'h0, analog.latch});
    wr(DACCTL_ADDR_STAT, 16'h0002);
    pulse(1);
    chk("latch", 16'h0123, {4'h0, analog.latch});
    pulse(0);
    chk("latch", 16'h0555, {4'h0, analog.latch});
    rchk(DACCTL_ADDR_STAT, 16'h0003);
    wr(DACCTL_ADDR_STAT, 16'h0003);
    wr(DACCTL_ADDR_CTRL, 16'h0300);
    wr(DACCTL_ADDR_CODE, 16'h0666);
    pulse(1);
    chk("latch", 16'h0666, {4'h0, analog.latch});
    wr(DACCTL_ADDR_CTRL, 16'h0100);
    wr(DACCTL_ADDR_CODE, 16'h0777);
    pulse(0);
    pulse(1);
    chk("latch", 16'h0666, {4'h0, analog.latch});
    // dma: prompt and slow acceptance
    wr(DACCTL_ADDR_CTRL, 16'h0004);
    for (n = 0; n < 2; n++) begin
      ack_wait <= 4'(n * 5);
      wr(DACCTL_ADDR_CODE, 16'(n));
      wait_dma(1'b1);
      wait_dma(1'b0);
      rchk(DACCTL_ADDR_STAT, 16'h0002);
    end
    wr(DACCTL_ADDR_CTRL, 16'h0000);
    wr(DACCTL_ADDR_CODE, 16'h0042);
    repeat (3) @(posedge clock);
    #1 chk("dma_req", 16'h0, {15'h0, dma_req});
    rd(DACCTL_ADDR_VECTOR);
    // lock while on
    wr(DACCTL_ADDR_CTRL, 16'h1001);
    rchk(DACCTL_ADDR_CTRL, 16'h1001);
    chk("on", 16'h1, {15'h0, analog.dac_on});
    chk("ref", 16'h1, {15'h0, analog.reference_choice});
    wr(DACCTL_ADDR_CTRL, 16'h0007);
    rchk(DACCTL_ADDR_CTRL, 16'h1001);
    wr(DACCTL_ADDR_CODE, 16'h0099);
    wr(DACCTL_ADDR_STAT, 16'h0001);
    rchk(DACCTL_ADDR_STAT, 16'h0003);
    wr(DACCTL_ADDR_CTRL, 16'h0000);
    rchk(DACCTL_ADDR_CTRL, 16'h1000);
    wr(DACCTL_ADDR_CTRL, 16'h0000);
    rchk(DACCTL_ADDR_CTRL, 16'h0000);
    wr(DACCTL_ADDR_CELL, 16'h0400);
    rchk(DACCTL_ADDR_CELL, 16'h0400);
    chk("cell", 16'h1, {15'h0, analog.analog_cell_enable});
    // second reset in mid-run: every register back to zero
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    for (n = 0; n < 12; n += 2) rchk(4'(n), 16'h0000);
    chk("cell", 16'h0, {15'h0, analog.analog_cell_enable});
    end_sim();
  end
endmodule
